// *** hw/sig_pkg.sv ***
package sig_pkg;
  // ==========================================================
  // Sizes, positions and reset values
  localparam int NUM_LINES = 10;
  localparam logic [3:0] LINE_OVERFLOW = 4'h9;
  localparam logic [3:0] LINE_UNDERFLOW = 4'h0;
  localparam int ST_TRANSPARENT = 0;
  localparam int ST_SIGN = 1;
  localparam int ST_ENABLE = 2;
  localparam int ST_MASK_LSB = 6;
  localparam int ST_FRAME_SEL = 3;
  localparam int LIMIT_LSB = 4;
  localparam int VPTR_LSB = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [3:0] LIMIT_RESET = 4'h0;
  localparam logic [3:0] VPTR_RESET = 4'h0;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam logic [1:0] SS_FILL = 2'b00;
  localparam logic [1:0] RS_FILL = 2'b11;
  localparam logic [5:0] STACK_BOTTOM = 6'h00;
  localparam logic [5:0] PTR_STEP = 6'h01;
  localparam int SYNC_DELAY = 2;

  // ==========================================================
  // Instruction codes seen by the block
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_LIMIT_VPTR_LOAD = 4'b0001,
    OP_SIGN_CLEAR = 4'b0010,
    OP_RETURN = 4'b0011,
    OP_CLEAR_CURRENT = 4'b0100,
    OP_CLEAR_ALL = 4'b0101,
    OP_SELECT_UNLATCHED = 4'b0110,
    OP_SELECT_LATCHED = 4'b0111,
    OP_MASK_CLEAR = 4'b1000,
    OP_MASK_SET = 4'b1001,
    OP_STATUS_WRITE = 4'b1010,
    OP_VECTOR_WRITE = 4'b1011,
    OP_VECTOR_READ = 4'b1100,
    OP_ENABLE = 4'b1101,
    OP_DISABLE = 4'b1110
  } sig_op_t;

  typedef struct packed {
    logic valid;
    sig_op_t op;
    logic [15:0] data;
  } sig_instr_t;

  typedef struct packed {
    logic ss_push;
    logic ss_pop;
    logic rs_push;
    logic [5:0] return_stack_pointer;
    logic [5:0] local_frame_pointer;
    logic [5:0] shared_frame_pointer;
  } sig_stack_t;

  typedef struct packed {
    logic [15:0] status_word;
    logic [3:0] stack_limit;
    logic [3:0] vptr;
    logic [9:0] latch;
    logic handler_in_progress;
    logic [3:0] cur;
    logic override;
    logic [15:0] vector;
    logic push_ret;
    logic [15:0] dout;
    logic doe;
    logic [9:0][15:0] vfile;
  } sig_state_t;

  typedef struct packed {
    logic phase;
    logic [1:0] ph_pipe;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [7:0] cap;
  } sig_demux_t;
endpackage

// *** hw/sig_req_demux.sv ***
module sig_req_demux
  import sig_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic [3:0] pin_in, // Multiplexed request pins
  output logic phase_out, // Selector drive, 1 = upper group half
  output logic [7:0] req_out // Captured levels of lines 8 to 1
);
  sig_demux_t q, d;

  // ==========================================================
  // Two-flop synchroniser, then alternate-cycle demultiplexing
  always_comb
  begin
    d = q;
    d.phase = ~q.phase;
    d.ph_pipe = {q.ph_pipe[0], q.phase}; // Phase seen with the synchronised pins
    d.s1 = pin_in;
    d.s2 = q.s1;
    if (q.ph_pipe[SYNC_DELAY-1])
    begin
      d.cap[7:4] = q.s2; // Upper group lands on lines 8 to 5
    end
    else
    begin
      d.cap[3:0] = q.s2; // Lower group lands on lines 4 to 1
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign phase_out = q.phase;
  assign req_out = q.cap;
endmodule

// *** hw/sig_prio.sv ***
module sig_prio
  import sig_pkg::*;
(
  input wire logic [9:0] req_in, // Unmasked pending lines
  output logic valid_out, // Any line pending
  output logic [3:0] idx_out // Most urgent line number
);
  // ==========================================================
  // Later iterations win, so line 9 is the most urgent
  always_comb
  begin
    valid_out = 1'b0;
    idx_out = 4'h0;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (req_in[i])
      begin
        valid_out = 1'b1;
        idx_out = 4'(i);
      end
    end
  end
endmodule

// *** hw/sig_guard.sv ***
module sig_guard
  import sig_pkg::*;
(
  input wire logic CORE_CLK_IN, // Core clock, 100 MHz
  input wire logic RESET_N_IN, // Synchronous reset, active low
  input wire logic [3:0] EXTERNAL_REQUEST_PIN_IN, // Request pins, active high
  input wire logic INSTR_VALID_IN, // Instruction strobe
  input wire logic [3:0] INSTR_OP_IN, // Instruction code
  input wire logic [15:0] DATA_IN, // Data port, inbound
  input wire logic SS_PUSH_IN, // Subroutine stack push
  input wire logic SS_POP_IN, // Subroutine stack pop
  input wire logic RS_PUSH_IN, // Frame stack push
  input wire logic [5:0] RETURN_STACK_POINTER_IN, // Pointer before the operation
  input wire logic [5:0] LOCAL_FRAME_POINTER_IN, // Local frame pointer
  input wire logic [5:0] SHARED_FRAME_POINTER_IN, // Shared frame pointer
  input wire logic COUNTER_UNDERFLOW_IN, // Counter underflow pulse
  output logic ADDR_OVERRIDE_OUT, // Vector replaces normal address
  output logic [15:0] VECTOR_OUT, // Vector on the address port
  output logic PUSH_RETURN_OUT, // Push the return address now
  output logic [15:0] DATA_OUT, // Data port, outbound
  output logic DATA_OE_OUT, // Data port drive enable
  output logic [15:0] STATUS_OUT, // Status word
  output logic HANDLER_IN_PROGRESS_OUT, // Lockout active
  output logic [9:0] PENDING_OUT, // Latched lines
  output logic HALF_SELECT_OUT // External selector drive
);
  sig_state_t q, d;
  sig_instr_t instr;
  sig_stack_t stk;
  logic [7:0] ext_req;
  logic [9:0] set_c;
  logic [9:0] clr_c;
  logic [9:0] pending_c;
  logic [9:0] unmasked_c;
  logic pick_valid;
  logic [3:0] pick_idx;
  logic accept_c;
  logic instr_ok;
  logic ss_over_c;
  logic ss_under_c;
  logic rs_over_c;
  logic [5:0] frame_ptr;

  // Same-clock inputs gathered into carriers
  assign instr = '{valid: INSTR_VALID_IN, op: sig_op_t'(INSTR_OP_IN), data: DATA_IN};
  assign stk = '{ss_push: SS_PUSH_IN, ss_pop: SS_POP_IN, rs_push: RS_PUSH_IN,
                 return_stack_pointer: RETURN_STACK_POINTER_IN,
                 local_frame_pointer: LOCAL_FRAME_POINTER_IN,
                 shared_frame_pointer: SHARED_FRAME_POINTER_IN};

  // ==========================================================
  // Request pins
  sig_req_demux u_demux (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .pin_in(EXTERNAL_REQUEST_PIN_IN),
    .phase_out(HALF_SELECT_OUT),
    .req_out(ext_req)
  );

  // ==========================================================
  // Stack limit comparison
  always_comb
  begin
    frame_ptr = q.status_word[ST_FRAME_SEL] ? stk.shared_frame_pointer
                                            : stk.local_frame_pointer;
    // All six bits are compared, the low two against SS_FILL or RS_FILL
    ss_over_c = stk.ss_push &&
      ((stk.return_stack_pointer + PTR_STEP) == {q.stack_limit, SS_FILL});
    ss_under_c = stk.ss_pop && (stk.return_stack_pointer == STACK_BOTTOM);
    rs_over_c = stk.rs_push &&
      ((frame_ptr - PTR_STEP) == {q.stack_limit, RS_FILL});
  end

  // ==========================================================
  // Latch sets and clears
  // The first handler instruction runs while the return push happens and is dropped
  assign instr_ok = instr.valid && !q.push_ret;

  always_comb
  begin
    set_c = '0;
    clr_c = '0;
    set_c[LINE_OVERFLOW] = ss_over_c || ss_under_c || rs_over_c;
    set_c[LINE_UNDERFLOW] = COUNTER_UNDERFLOW_IN;
    if (!q.status_word[ST_TRANSPARENT])
    begin
      set_c[8:1] = ext_req; // Levels collected, held until cleared
    end
    if (instr_ok)
    begin
      case (instr.op)
        OP_LIMIT_VPTR_LOAD: clr_c[LINE_OVERFLOW] = 1'b1;
        OP_SIGN_CLEAR: clr_c[LINE_UNDERFLOW] = 1'b1;
        OP_RETURN, OP_CLEAR_CURRENT:
        begin
          if (q.cur != LINE_OVERFLOW && q.cur != LINE_UNDERFLOW)
          begin
            clr_c[q.cur] = 1'b1;
          end
        end
        OP_CLEAR_ALL: clr_c[8:1] = '1;
        default: clr_c = '0;
      endcase
    end
  end

  // ==========================================================
  // Pending, masking and acceptance
  // Fresh events join at once so a vector follows detection by one cycle
  always_comb
  begin
    pending_c = q.latch | set_c;
    if (q.status_word[ST_TRANSPARENT])
    begin
      pending_c[8:1] = ext_req; // Latch bypassed, source must hold
    end
    unmasked_c = pending_c & ~q.status_word[15:ST_MASK_LSB];
  end

  sig_prio u_prio (
    .req_in(unmasked_c),
    .valid_out(pick_valid),
    .idx_out(pick_idx)
  );

  // Disabled or locked out requests stay latched but do not vector
  assign accept_c = pick_valid && q.status_word[ST_ENABLE] &&
                    !q.handler_in_progress;

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    d.latch = (q.latch & ~clr_c) | set_c; // Set beats clear in the same cycle
    d.override = accept_c;
    d.vector = accept_c ? q.vfile[pick_idx] : q.vector;
    d.push_ret = q.override;
    d.doe = 1'b0;
    if (accept_c)
    begin
      d.cur = pick_idx;
    end
    if (instr_ok)
    begin
      case (instr.op)
        OP_LIMIT_VPTR_LOAD:
        begin
          d.stack_limit = instr.data[LIMIT_LSB +: 4];
          d.vptr = instr.data[VPTR_LSB +: 4];
        end
        OP_SIGN_CLEAR: d.status_word[ST_SIGN] = 1'b0;
        OP_SELECT_UNLATCHED: d.status_word[ST_TRANSPARENT] = 1'b1;
        OP_SELECT_LATCHED: d.status_word[ST_TRANSPARENT] = 1'b0;
        OP_MASK_CLEAR:
          d.status_word[15:ST_MASK_LSB] = q.status_word[15:ST_MASK_LSB] &
                                          ~instr.data[15:ST_MASK_LSB];
        OP_MASK_SET:
          d.status_word[15:ST_MASK_LSB] = q.status_word[15:ST_MASK_LSB] |
                                          instr.data[15:ST_MASK_LSB];
        OP_STATUS_WRITE: d.status_word = instr.data;
        OP_VECTOR_WRITE:
        begin
          if (q.vptr < LINE_OVERFLOW + 4'h1)
          begin
            d.vfile[q.vptr] = instr.data;
          end
        end
        OP_VECTOR_READ:
        begin
          // Pointer values past the file read as zero
          d.dout = (q.vptr < LINE_OVERFLOW + 4'h1) ? q.vfile[q.vptr] : '0;
          d.doe = 1'b1;
        end
        OP_ENABLE: d.status_word[ST_ENABLE] = 1'b1;
        OP_DISABLE: d.status_word[ST_ENABLE] = 1'b0;
        default: d.dout = q.dout;
      endcase
    end
    // Lockout released by return or either clear; a new acceptance wins
    if (accept_c)
    begin
      d.handler_in_progress = 1'b1;
    end
    else if (instr_ok && (instr.op == OP_RETURN || instr.op == OP_CLEAR_CURRENT ||
                          instr.op == OP_CLEAR_ALL))
    begin
      d.handler_in_progress = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      q <= '0; // Latch and lockout empty at start
      q.status_word <= STATUS_RESET;
      q.stack_limit <= LIMIT_RESET;
      q.vptr <= VPTR_RESET;
      q.vector <= VECTOR_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign ADDR_OVERRIDE_OUT = q.override;
  assign VECTOR_OUT = q.vector;
  assign PUSH_RETURN_OUT = q.push_ret;
  assign DATA_OUT = q.dout;
  assign DATA_OE_OUT = q.doe;
  assign STATUS_OUT = q.status_word;
  assign HANDLER_IN_PROGRESS_OUT = q.handler_in_progress;
  assign PENDING_OUT = q.latch;

  // ==========================================================
  // Checks
  sequence overflow_seen;
    ss_over_c && !q.status_word[15] && q.status_word[ST_ENABLE] && !q.handler_in_progress;
  endsequence

  sequence vector_nine;
    q.override && q.cur == LINE_OVERFLOW && q.vector == $past(q.vfile[9]);
  endsequence

  sequence push_pulse;
    q.push_ret ##1 !q.push_ret;
  endsequence

  overflow_vector_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    overflow_seen |=> vector_nine)
    else $error("Overflow vector not output next cycle");

  bottom_pop_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (SS_POP_IN && RETURN_STACK_POINTER_IN == 6'h00) |=> q.latch[9])
    else $error("Pop from location zero did not raise line 9");

  frame_limit_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (RS_PUSH_IN && !q.status_word[3] && LOCAL_FRAME_POINTER_IN == {q.stack_limit, 2'b11} + 6'h01)
    |=> q.latch[9])
    else $error("Frame push to limit plus three did not raise line 9");

  mask_block_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    accept_c |-> !q.status_word[ST_MASK_LSB + int'(pick_idx)])
    else $error("Masked line accepted");

  return_push_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    $rose(q.override) |=> push_pulse)
    else $error("Return push not one cycle after vector");

  lockout_hold_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    q.handler_in_progress |-> !q.override || $past(!q.handler_in_progress))
    else $error("Vector output during lockout");

  disabled_quiet_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    !q.status_word[ST_ENABLE] |=> !q.override)
    else $error("Vector output while disabled");

  latch_keep_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    1'b1 |=> (($past(q.latch) & ~$past(clr_c) & ~q.latch) == 10'h000))
    else $error("Pending line lost without a clear");

  mask_set_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_MASK_SET) |=>
    q.status_word[15:6] == ($past(q.status_word[15:6]) | $past(DATA_IN[15:6])))
    else $error("Mask set wrong");

  // Selector must alternate every cycle or a group is never sampled
  half_toggle_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    1'b1 |=> HALF_SELECT_OUT != $past(HALF_SELECT_OUT))
    else $error("Half select did not toggle");

  ss_limit_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (SS_PUSH_IN && (RETURN_STACK_POINTER_IN + 6'h01) == {q.stack_limit, 2'b00}) |=> q.latch[9])
    else $error("Subroutine push to limit did not raise line 9");

  underflow_set_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    COUNTER_UNDERFLOW_IN |=> q.latch[0])
    else $error("Counter underflow not latched");

  ext_latch_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    !q.status_word[ST_TRANSPARENT] |=> ((q.latch[8:1] & $past(ext_req)) == $past(ext_req)))
    else $error("Captured request not latched");

  transparent_bypass_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    q.status_word[ST_TRANSPARENT] |=> ((q.latch[8:1] & ~$past(q.latch[8:1])) == 8'h00))
    else $error("Request latched in transparent mode");

  sign_clear_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_SIGN_CLEAR && !COUNTER_UNDERFLOW_IN) |=>
    !q.latch[0] && !q.status_word[ST_SIGN])
    else $error("Sign clear left line 0 pending");

  limit_load_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_LIMIT_VPTR_LOAD && !ss_over_c && !ss_under_c && !rs_over_c)
    |=> !q.latch[9] && q.stack_limit == $past(DATA_IN[7:4]))
    else $error("Limit load did not clear line 9");

  clear_all_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_CLEAR_ALL && !q.status_word[ST_TRANSPARENT]) |=>
    q.latch[8:1] == $past(ext_req))
    else $error("Clear all left user lines pending");

  return_release_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_RETURN && q.handler_in_progress) |=> !q.handler_in_progress)
    else $error("Return did not release lockout");

  push_after_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    q.push_ret |-> $past(q.override))
    else $error("Return push without a vector");

  first_ignored_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    q.push_ret |=> $stable(q.status_word))
    else $error("First handler instruction not ignored");

  pick_top_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    accept_c |-> (unmasked_c >> pick_idx) == 10'h001)
    else $error("Accepted line is not the most urgent");

  read_data_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (instr_ok && instr.op == OP_VECTOR_READ && q.vptr <= LINE_OVERFLOW) |=>
    DATA_OE_OUT && DATA_OUT == $past(q.vfile[q.vptr]))
    else $error("Vector read returned wrong data");

  oe_pulse_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    DATA_OE_OUT |-> $past(instr_ok && instr.op == OP_VECTOR_READ))
    else $error("Data drive without a read");
endmodule

// *** testbench/sig_src_model.sv ***
// ==========================================================
// Far side: external requesters behind a two-to-one selector
module sig_src_model
  import sig_pkg::*;
(
  input wire logic half_sel_in, // Selector drive from the block
  input wire logic [7:0] req_in, // Request levels, bit k is line k+1
  output logic [3:0] pin_out // Multiplexed request pins
);
  // Upper group while the block asks for it, lower group otherwise
  // Active-high levels; idle requesters sit at 0, never floating
  always_comb pin_out = half_sel_in ? req_in[7:4] : req_in[3:0];
endmodule

// *** testbench/sequencer_interrupt_stack_guard_tb.sv ***
// ==========================================================
// Self-checking bench for the interrupt and stack guard
module sequencer_interrupt_stack_guard_tb
  import sig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    sig_op_t op;
    logic [15:0] data;
    logic [15:0] status;
  } sig_row_t;
  logic clk, rst_n, valid, ss_push, ss_pop, rs_push, cu;
  logic [3:0] op, pins;
  logic [15:0] data;
  logic [5:0] rsp, lfp, sfp;
  logic [7:0] req;
  logic ovr, push_ret, doe, hip, half;
  logic [15:0] vec, dout, status;
  logic [9:0] pend;
  int fails = 0;
  int tests_run = 0;
  // Mode bits must ignore low data bits of mask operations
  sig_row_t rows[10] = '{
    '{OP_STATUS_WRITE, 16'h0000, 16'h0000}, '{OP_MASK_SET, 16'hFFC0, 16'hFFC0},
    '{OP_MASK_CLEAR, 16'h0A40, 16'hF580}, '{OP_MASK_SET, 16'h003F, 16'hF580},
    '{OP_MASK_CLEAR, 16'h003F, 16'hF580}, '{OP_ENABLE, 16'h0000, 16'hF584},
    '{OP_SELECT_UNLATCHED, 16'h0000, 16'hF585}, '{OP_SELECT_LATCHED, 16'h0000, 16'hF584},
    '{OP_DISABLE, 16'h0000, 16'hF580}, '{OP_MASK_CLEAR, 16'hFFC0, 16'h0000}};

  sig_guard sig_guard_i (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .EXTERNAL_REQUEST_PIN_IN(pins), .INSTR_VALID_IN(valid), .INSTR_OP_IN(op),
    .DATA_IN(data), .SS_PUSH_IN(ss_push), .SS_POP_IN(ss_pop), .RS_PUSH_IN(rs_push),
    .RETURN_STACK_POINTER_IN(rsp), .LOCAL_FRAME_POINTER_IN(lfp),
    .SHARED_FRAME_POINTER_IN(sfp), .COUNTER_UNDERFLOW_IN(cu),
    .ADDR_OVERRIDE_OUT(ovr), .VECTOR_OUT(vec), .PUSH_RETURN_OUT(push_ret),
    .DATA_OUT(dout), .DATA_OE_OUT(doe), .STATUS_OUT(status),
    .HANDLER_IN_PROGRESS_OUT(hip), .PENDING_OUT(pend), .HALF_SELECT_OUT(half));
  sig_src_model sig_src_model_i (.half_sel_in(half), .req_in(req), .pin_out(pins));

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole sequence is a few hundred cycles; this is far beyond it
  initial
  begin
    #400000;
    fails++;
    final_report();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic instr(input sig_op_t o, input logic [15:0] d);
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    data <= d;
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask
  // Poll a bounded number of cycles for the vector, then step into the push cycle
  task automatic wait_vec(input logic [15:0] exp);
    int n = 0;
    while (ovr !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(ovr, 1'b1);
    chk(vec, exp);
    @(posedge clk);
    #1;
  endtask
  // kind 0 subroutine push, 1 subroutine pop, 2 frame push
  task automatic stk(input int kind, input logic [5:0] p, input logic hit);
    @(posedge clk);
    ss_push <= (kind == 0);
    ss_pop <= (kind == 1);
    rs_push <= (kind == 2);
    rsp <= p;
    lfp <= p;
    @(posedge clk);
    {ss_push, ss_pop, rs_push} <= 3'b000;
    #1;
    chk1(ovr, hit);
    if (hit)
    begin
      chk(vec, 16'hA009);
      chk1(hip, 1'b1);
      @(posedge clk);
      valid <= 1'b1;
      op <= OP_MASK_SET;
      data <= 16'hFFC0;
      #1;
      chk1(push_ret, 1'b1);
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk(status, 16'h0004);
      instr(OP_LIMIT_VPTR_LOAD, 16'h0020);
      chk1(pend[9], 1'b0);
      instr(OP_RETURN, 16'h0000);
      chk1(hip, 1'b0);
    end
    else
      chk({6'h00, pend}, 16'h0000);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    {valid, ss_push, ss_pop, rs_push, cu} = 5'b00000;
    op = 4'h0;
    data = 16'h0000;
    {rsp, lfp, sfp} = 18'h00000;
    req = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(status, 16'h0000);
    chk({6'h00, pend}, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      instr(rows[i].op, rows[i].data);
      chk(status, rows[i].status);
    end
    // Vector file through the pointer; pointer 10 lies beyond the file
    for (int k = 0; k < 11; k++)
    begin
      instr(OP_LIMIT_VPTR_LOAD, {12'h000, 4'(k)});
      instr(OP_VECTOR_WRITE, 16'hA000 + 16'(k));
      instr(OP_VECTOR_READ, 16'h0000);
      chk1(doe, 1'b1);
      chk(dout, (k < 10) ? 16'hA000 + 16'(k) : 16'h0000);
    end
    instr(OP_LIMIT_VPTR_LOAD, 16'h0020);
    instr(OP_STATUS_WRITE, 16'h0004);
    stk(0, 6'd7, 1'b1);
    stk(0, 6'd10, 1'b0);
    stk(1, 6'd0, 1'b1);
    stk(1, 6'd5, 1'b0);
    stk(2, 6'd9, 1'b0);
    stk(2, 6'd12, 1'b1);
    // Masked overflow stays pending and vectors once unmasked
    instr(OP_MASK_SET, 16'h8000);
    @(posedge clk);
    ss_push <= 1'b1;
    rsp <= 6'd7;
    @(posedge clk);
    ss_push <= 1'b0;
    #1;
    chk1(ovr, 1'b0);
    chk1(pend[9], 1'b1);
    instr(OP_MASK_CLEAR, 16'h8000);
    wait_vec(16'hA009);
    instr(OP_LIMIT_VPTR_LOAD, 16'h0020);
    instr(OP_RETURN, 16'h0000);
    // Counter underflow while disabled, cleared only by sign clear
    instr(OP_DISABLE, 16'h0000);
    @(posedge clk);
    cu <= 1'b1;
    @(posedge clk);
    cu <= 1'b0;
    #1;
    chk({6'h00, pend}, 16'h0001);
    chk1(ovr, 1'b0);
    instr(OP_CLEAR_ALL, 16'h0000);
    chk({6'h00, pend}, 16'h0001);
    instr(OP_SIGN_CLEAR, 16'h0000);
    chk({6'h00, pend}, 16'h0000);
    // Lines 7 and 2 from both halves, withdrawn before service
    @(posedge clk);
    req <= 8'h42;
    repeat (8) @(posedge clk);
    req <= 8'h00;
    repeat (4) @(posedge clk);
    #1;
    chk({6'h00, pend}, 16'h0084);
    instr(OP_ENABLE, 16'h0000);
    wait_vec(16'hA007);
    repeat (3)
    begin
      @(posedge clk);
      #1;
      chk1(ovr, 1'b0);
    end
    instr(OP_RETURN, 16'h0000);
    chk({6'h00, pend}, 16'h0004);
    wait_vec(16'hA002);
    instr(OP_CLEAR_CURRENT, 16'h0000);
    chk({6'h00, pend}, 16'h0000);
    chk1(hip, 1'b0);
    // Reset in mid-run with a request pending
    instr(OP_DISABLE, 16'h0000);
    @(posedge clk);
    req <= 8'h10;
    repeat (8) @(posedge clk);
    #1;
    chk({6'h00, pend}, 16'h0020);
    @(posedge clk);
    rst_n <= 1'b0;
    req <= 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({6'h00, pend}, 16'h0000);
    chk1(hip, 1'b0);
    chk(status, 16'h0000);
    // Selector restarts from the lower group and flips on the next edge
    chk1(half, 1'b0);
    @(posedge clk);
    #1;
    chk1(half, 1'b1);
    chk1(ovr, 1'b0);
    final_report();
  end
endmodule
